// ===== rtl/scp_pkg.sv
package scp_pkg;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 8;
  localparam int REG_COUNT = 256;
  // Rate-selection register addresses and bit positions
  localparam logic [7:0] RATE_REG_A = 8'h34;
  localparam int RATE_A_BIT = 2;
  localparam logic [7:0] RATE_REG_B = 8'h38;
  localparam int RATE_B_BIT_LO = 5;
  localparam int RATE_B_BIT_HI = 6;
  localparam logic [7:0] RATE_REG_C = 8'h64;
  localparam int RATE_C_BIT = 4;
  // Register reset value
  localparam logic [7:0] REG_RESET = 8'h00;
  // Frame: read flag plus seven address bits, then eight data bits
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_PHASE_BITS = 5'h08;
endpackage : scp_pkg

// ===== rtl/scp_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; a change counts once stages two and three agree
module scp_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_value,
  // Data
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } scp_sync_s;
  scp_sync_s st;
  scp_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.out = st.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.out ^ reset_value;
endmodule : scp_sync

// ===== rtl/scp_port.sv
`timescale 1ns/10ps
// Functional notes
// [R1] Select low opens access; high ignores pins
// [R2] Edge select 1: falling edge is active
// [R3] Input bit captured on active clock edge
// [R4] Read data shifted out on serial_out
// [R5] Power-on reset returns all state to defaults
// [R6] Strap loads rate bits at reset release
// [R7] Host writes may overwrite rate bits
// [R8] Registers 8-bit wide, 8-bit address; the frame carries seven address bits and the top address bit is held 0
// [R9] Edge select 0: rising edge is active
// [R10] Address phase, eight data bits, one frame
module scp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial port pins
  input wire logic port_select_n,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Configuration pins
  input wire logic sclk_edge_select,
  input wire logic power_on_reset_n,
  input wire logic rate_strap,
  // Rate selection state
  output logic rate_sonet_a,
  output logic [1:0] rate_sonet_b,
  output logic rate_sonet_c
);
  typedef enum logic [1:0] {IDLE, SHIFT, DONE} scp_state_e;
  typedef struct packed {
    scp_state_e state;
    logic sclk_d;
    logic por_d;
    logic strap_pending;
    logic [4:0] count;
    logic [7:0] addr;
    logic [7:0] shreg;
    logic rd;
    logic so;
    logic oe;
    logic [7:0] rate_a;
    logic [7:0] rate_b;
    logic [7:0] rate_c;
  } scp_port_s;

  scp_port_s st;
  scp_port_s next_st;
  logic [7:0] regs [scp_pkg::REG_COUNT];
  logic cs_n_s;
  logic sclk_s;
  logic serial_in_s;
  logic por_s;
  logic strap_s;
  logic active_edge;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  // Select reads deselected while the pipeline is in reset
  scp_sync u_sync_cs (
    .clk(clk),
    .rst_n(rst_n),
    .reset_value(1'b1),
    .din(~port_select_n),
    .dout(cs_n_s)
  );
  // Same depth as data so bit and edge stay in step
  scp_sync u_sync_clk (
    .clk(clk),
    .rst_n(rst_n),
    .reset_value(1'b0),
    .din(sclk),
    .dout(sclk_s)
  );
  scp_sync u_sync_di (
    .clk(clk),
    .rst_n(rst_n),
    .reset_value(1'b0),
    .din(serial_in),
    .dout(serial_in_s)
  );
  // Reads low after rst_n so the strap load always follows
  scp_sync u_sync_por (
    .clk(clk),
    .rst_n(rst_n),
    .reset_value(1'b0),
    .din(power_on_reset_n),
    .dout(por_s)
  );
  scp_sync u_sync_strap (
    .clk(clk),
    .rst_n(rst_n),
    .reset_value(1'b0),
    .din(rate_strap),
    .dout(strap_s)
  );

  // Rising or falling edge per edge select
  always_comb begin
    if (sclk_edge_select) begin
      active_edge = st.sclk_d & ~sclk_s; // [R2]
    end else begin
      active_edge = ~st.sclk_d & sclk_s; // [R9] [R3]
    end
  end

  // Rate registers live in the struct; others in the array
  always_comb begin
    case (st.addr)
      scp_pkg::RATE_REG_A: rd_data = st.rate_a;
      scp_pkg::RATE_REG_B: rd_data = st.rate_b;
      scp_pkg::RATE_REG_C: rd_data = st.rate_c;
      default: rd_data = regs[st.addr];
    endcase
  end

  always_comb begin
    next_st = st;
    wr_en = 1'b0;
    wr_addr = st.addr;
    wr_data = st.shreg;
    next_st.sclk_d = sclk_s;
    next_st.por_d = por_s;
    if (por_s && !st.por_d) begin
      next_st.strap_pending = 1'b1;
    end
    if (st.strap_pending) begin
      next_st.strap_pending = 1'b0;
      next_st.rate_a[scp_pkg::RATE_A_BIT] = strap_s; // [R6]
      next_st.rate_b[scp_pkg::RATE_B_BIT_LO] = strap_s; // [R6]
      next_st.rate_b[scp_pkg::RATE_B_BIT_HI] = strap_s; // [R6]
      next_st.rate_c[scp_pkg::RATE_C_BIT] = strap_s; // [R6]
    end
    if (cs_n_s) begin
      // Deselected: pins ignored, frame abandoned
      next_st.state = IDLE; // [R1]
      next_st.oe = 1'b0;
      next_st.count = '0;
    end else begin
      case (st.state)
        IDLE: begin
          next_st.state = SHIFT;
          next_st.count = '0;
          next_st.oe = 1'b0;
        end
        SHIFT: begin
          if (active_edge) begin
            next_st.shreg = {st.shreg[6:0], serial_in_s}; // [R3]
            next_st.count = st.count + 5'h01;
            if (st.count == scp_pkg::ADDR_PHASE_BITS - 5'h01) begin
              // First bit is read flag, rest is address
              next_st.rd = st.shreg[6];
              next_st.addr = {1'b0, st.shreg[5:0], serial_in_s}; // [R8]
            end
            if (st.rd && st.count >= scp_pkg::ADDR_PHASE_BITS) begin
              // Top bit already shown since load; next one follows
              next_st.so = st.shreg[6]; // [R4]
            end
            if (st.count == scp_pkg::FRAME_BITS - 5'h01) begin
              next_st.state = DONE; // [R10]
              next_st.oe = 1'b0;
              if (!st.rd) begin
                wr_en = 1'b1;
                wr_data = {st.shreg[6:0], serial_in_s};
              end
            end
          end
          if (st.count == scp_pkg::ADDR_PHASE_BITS && st.rd && !st.oe) begin
            next_st.shreg = rd_data;
            next_st.so = rd_data[7]; // [R4]
            next_st.oe = 1'b1; // [R10]
          end
        end
        DONE: begin
          next_st.state = DONE;
        end
        default: begin
          next_st.state = IDLE;
        end
      endcase
    end
    if (wr_en) begin
      case (wr_addr)
        scp_pkg::RATE_REG_A: next_st.rate_a = wr_data; // [R7]
        scp_pkg::RATE_REG_B: next_st.rate_b = wr_data; // [R7]
        scp_pkg::RATE_REG_C: next_st.rate_c = wr_data; // [R7]
        default: begin
        end
      endcase
    end
    if (!por_s) begin
      next_st = '0; // [R5]
      next_st.state = IDLE;
      next_st.sclk_d = sclk_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= IDLE;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < scp_pkg::REG_COUNT; i++) begin
        regs[i] <= scp_pkg::REG_RESET;
      end
    end else if (!por_s) begin
      for (int i = 0; i < scp_pkg::REG_COUNT; i++) begin
        regs[i] <= scp_pkg::REG_RESET; // [R5]
      end
    end else if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end
  end

  assign serial_out = st.so;
  assign serial_out_oe = st.oe;
  assign rate_sonet_a = st.rate_a[scp_pkg::RATE_A_BIT];
  assign rate_sonet_b = {st.rate_b[scp_pkg::RATE_B_BIT_HI], st.rate_b[scp_pkg::RATE_B_BIT_LO]};
  assign rate_sonet_c = st.rate_c[scp_pkg::RATE_C_BIT];
endmodule : scp_port

// ===== sim/scp_port_sva.sv
`timescale 1ns/10ps
module scp_port_sva (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Port and reset pins
  input logic port_select_n,
  input logic serial_out_oe,
  input logic power_on_reset_n,
  input logic rate_strap,
  // Rate state
  input logic rate_sonet_a,
  input logic [1:0] rate_sonet_b,
  input logic rate_sonet_c
);
  logic [3:0] rates;
  assign rates = {rate_sonet_a, rate_sonet_b, rate_sonet_c};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence por_up;
    $rose(power_on_reset_n) ##1 (power_on_reset_n && $stable(rate_strap)) [*8];
  endsequence
  sequence por_low;
    !power_on_reset_n [*6];
  endsequence
  rst_clear_a: assert property ($rose(rst_n) |-> rates == 4'h0 && !serial_out_oe)
    else $error("reset");
  por_clear_a: assert property (por_low |-> rates == 4'h0)
    else $error("por rates");
  por_quiet_a: assert property (por_low |-> !serial_out_oe)
    else $error("por oe");
  strap_load_a: assert property (por_up |-> ##4 rates == {4{rate_strap}})
    else $error("strap");
  oe_framed_a: assert property (serial_out_oe |-> !$past(port_select_n, 8))
    else $error("oe frame");
  oe_drop_a: assert property ($rose(port_select_n) |-> ##[1:8] !serial_out_oe)
    else $error("oe drop");
  read_keep_a: assert property (serial_out_oe |-> $stable(rates))
    else $error("read wrote");
  oe_hold_a: assert property ($rose(serial_out_oe) |-> serial_out_oe [*8])
    else $error("oe hold");
endmodule : scp_port_sva

// ===== sim/scp_host.sv
`timescale 1ns/10ps
module scp_host (
  // Clock
  input logic clk,
  // Serial pins
  output logic port_select_n,
  output logic sclk,
  output logic serial_in,
  input logic serial_out,
  input logic sclk_edge_select
);
  initial begin
    port_select_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end
  task automatic xfer(input logic rd, logic [7:0] a, logic [7:0] wd, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a[6:0], wd};
    port_select_n = 1'b0;
    sclk = sclk_edge_select;
    serial_in = f[15];
    repeat (8) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      if (i < 8) q[i] = serial_out;
      sclk = ~sclk_edge_select;
      repeat (4) @(negedge clk);
      sclk = sclk_edge_select;
      repeat (2) @(negedge clk);
      serial_in = (i > 0) ? f[i-1] : 1'b0;
      repeat (2) @(negedge clk);
    end
    port_select_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask : xfer
  // Clock edges while deselected
  task automatic noise();
    repeat (16) begin
      sclk = ~sclk;
      repeat (4) @(negedge clk);
    end
  endtask : noise
endmodule : scp_host

// ===== sim/serial_config_port_tb_top.sv
`timescale 1ns/10ps
module serial_config_port_tb_top;
  logic clk, rst_n, port_select_n, sclk, serial_in, serial_out, serial_out_oe;
  logic sclk_edge_select, power_on_reset_n, rate_strap, rate_sonet_a, rate_sonet_c;
  logic [1:0] rate_sonet_b;
  logic [7:0] q;
  int mismatches, samples_checked;
  scp_port dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .port_select_n(port_select_n),
    .sclk(sclk),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .sclk_edge_select(sclk_edge_select),
    .power_on_reset_n(power_on_reset_n),
    .rate_strap(rate_strap),
    .rate_sonet_a(rate_sonet_a),
    .rate_sonet_b(rate_sonet_b),
    .rate_sonet_c(rate_sonet_c)
  );
  scp_host host_u (
    .clk(clk),
    .port_select_n(port_select_n),
    .sclk(sclk),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .sclk_edge_select(sclk_edge_select)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(string n, logic [7:0] e, s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic rd(logic [7:0] a, e);
    host_u.xfer(1'b1, a, 8'h00, q);
    chk("rdata", e, q);
  endtask : rd
  task automatic test_done();
    $display("checked %0d bad %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    rst_n = 1'b0;
    sclk_edge_select = 1'b0;
    power_on_reset_n = 1'b1;
    rate_strap = 1'b1;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    rd(8'h34, 8'h04);
    rd(8'h38, 8'h60);
    rd(8'h64, 8'h10);
    chk("rate_a", 8'h01, {7'h00, rate_sonet_a});
    chk("rate_b", 8'h03, {6'h00, rate_sonet_b});
    chk("rate_c", 8'h01, {7'h00, rate_sonet_c});
    rd(8'h7f, 8'h00);
    host_u.xfer(1'b0, 8'h38, 8'h5a, q);
    chk("rate_b", 8'h02, {6'h00, rate_sonet_b});
    host_u.noise();
    rd(8'h38, 8'h5a);
    sclk_edge_select = 1'b1;
    host_u.xfer(1'b0, 8'h64, 8'ha5, q);
    chk("rate_c", 8'h00, {7'h00, rate_sonet_c});
    rd(8'h64, 8'ha5);
    rate_strap = 1'b0;
    power_on_reset_n = 1'b0;
    repeat (10) @(negedge clk);
    power_on_reset_n = 1'b1;
    repeat (12) @(negedge clk);
    rd(8'h38, 8'h00);
    rd(8'h64, 8'h00);
    chk("rate_a", 8'h00, {7'h00, rate_sonet_a});
    rate_strap = 1'b1;
    power_on_reset_n = 1'b0;
    repeat (10) @(negedge clk);
    power_on_reset_n = 1'b1;
    repeat (12) @(negedge clk);
    chk("rate_b", 8'h03, {6'h00, rate_sonet_b});
    rd(8'h38, 8'h60);
    test_done();
  end
  initial begin
    #1000000;
    mismatches++;
    test_done();
  end
endmodule : serial_config_port_tb_top
bind scp_port scp_port_sva chk_u (
  .clk(clk),
  .rst_n(rst_n),
  .port_select_n(port_select_n),
  .serial_out_oe(serial_out_oe),
  .power_on_reset_n(power_on_reset_n),
  .rate_strap(rate_strap),
  .rate_sonet_a(rate_sonet_a),
  .rate_sonet_b(rate_sonet_b),
  .rate_sonet_c(rate_sonet_c)
);
